/* File: hw/mef_top.v */
// Event flag, mask and interrupt logic of a PSK modem, with equaliser routing.
// Assumes a synchronous host register port (address, read and write strobes)
// and datapath event strobes from the modem core, all on ref_clk.
// Status levels are taken as already synchronous; only ring gets one extra register stage.
// Window lateness is flagged unless a rearm guard holds it off, and on transmit always starts the ones filler; the host owns the servicing deadline.
//
// Notes on behaviour
// R1: Enabled flag setting raises interrupt request
// R2: Flag register read clears all flags
// R3: Bit 7 set on receive parity error
// R4: Bit 6 set on ringing status change
// R5: Bit 5 set on tone status change
// R6: Bit 3 set when receive byte ready
// R7: Host reads byte within eight bits
// R8: Bit 4 set on unread byte overrun
// R9: Bit 1 set when transmit slot free
// R10: Host writes byte within eight bits
// R11: Bit 2 set on late transmit byte
// R12: Bit 0 set on plain-ones status change
// R13: Each path routed through its band equaliser
// R14: Same band on both paths bypasses equalisers
// R15: Ringing status follows ring timing detector
// R16: Host times ringing bit to classify
// R17: Mask bit enables matching flag interrupt
// R18: Receive flags rearm only after byte read
// R19: Underflow sends continuous ones until write
// R20: Receive holder double buffered, eight-bit updates
// R21: Request active low, held until read
`include "mef_map.vh"
module mef_top
(
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire [7:0] reg_addr,
    input  wire       reg_rd,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       bit_tick,
    input  wire       rx_byte_done,
    input  wire [7:0] rx_shift_byte,
    input  wire       rx_parity_bad,
    input  wire       tx_slot_free,
    input  wire       ring_timing_node,
    input  wire       progress_tone_status,
    input  wire       carrier_status,
    input  wire       answer_status,
    input  wire       plain_ones_status,
    input  wire       tx_band_select,
    input  wire       rx_band_select,
    output reg  [7:0] tx_byte,
    output wire       tx_send_ones,
    output wire       tx_eq_high,
    output wire       tx_eq_low,
    output wire       rx_eq_high,
    output wire       rx_eq_low,
    output wire       attention_request_low
);
    // ==========================================
    // State
    reg [7:0] event_flag_register;   // Sticky event flags
    reg [7:0] mask;                  // Interrupt enables
    reg [7:0] rx_hold;               // Host-visible receive byte
    reg       irq_pend;              // Latched request
    reg       rx_block;              // Receive flags held off
    reg       tx_block;              // Transmit flags held off
    reg       rx_unread;             // Holder not read yet
    reg       tx_empty;              // No byte loaded
    reg       underflow_run;         // Sending filler ones
    reg       ring_status;           // Ringing status bit

    wire [7:0] set_vec;              // Per-bit set requests
    wire [7:0] rise;                 // Flags going zero to one
    wire       ring_chg;             // Ringing status toggled
    wire       prog_chg;
    wire       carr_chg;
    wire       ans_chg;
    wire       plain_chg;
    wire       ovr_exp;
    wire       und_exp;
    wire       flag_rd;
    wire       byte_rd;
    wire       byte_wr;
    wire [7:0] tones;
    wire [4:0] status_vec;           // Status levels, ring first
    wire [4:0] status_chg;           // Per-level change pulses
    genvar     gi;                   // Detector index

    // Register port decodes; each strobe is exactly one access
    assign flag_rd = reg_rd & (reg_addr == `MEF_ADDR_FLAGS);
    assign byte_rd = reg_rd & (reg_addr == `MEF_ADDR_RXBYTE);
    assign byte_wr = reg_wr & (reg_addr == `MEF_ADDR_TXBYTE);

    // ==========================================
    // Change detectors on status bits
    // One detector per status level; ring is taken after its own
    // register, so its flag trails the pin by one more edge
    assign status_vec = {ring_status, progress_tone_status, carrier_status,
                         answer_status, plain_ones_status};
    assign ring_chg   = status_chg[4];
    assign prog_chg   = status_chg[3];
    assign carr_chg   = status_chg[2];
    assign ans_chg    = status_chg[1];
    assign plain_chg  = status_chg[0];

    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_edge
            mef_edge u_edge
            (
                .ref_clk (ref_clk),
                .rstn    (rstn),
                .level   (status_vec[gi]),
                .changed (status_chg[gi])
            );
        end
    endgenerate

    // ==========================================
    // Service windows; host side of each window is the host's duty [R7] [R10]
    // A window opens on each offer and closes on service or expiry
    // Expiry is a one-cycle pulse on the tick that ends the eighth period
    mef_window u_rxwin (.ref_clk(ref_clk), .rstn(rstn), .start(rx_byte_done),
                        .serviced(byte_rd), .bit_tick(bit_tick), .expired(ovr_exp));
    mef_window u_txwin (.ref_clk(ref_clk), .rstn(rstn), .start(tx_slot_free),
                        .serviced(byte_wr), .bit_tick(bit_tick), .expired(und_exp));

    // ==========================================
    // Ringing status follows the detector output
    // Registered once so every reader sees one level per cycle
    always @(posedge ref_clk)
    begin
        if (!rstn)
            ring_status <= 1'b0;
        else
            ring_status <= ring_timing_node;   // [R15]
    end

    // ==========================================
    // Set terms per flag bit
    // Receive terms obey the receive guard, transmit terms their own
    // Overrun also fires when a second byte lands on an unread one
    assign set_vec[`MEF_BIT_PARITY]    = rx_byte_done & rx_parity_bad & ~rx_block;  // [R3]
    assign set_vec[`MEF_BIT_RING]      = ring_chg;                                  // [R4]
    assign set_vec[`MEF_BIT_TONE]      = prog_chg | carr_chg | ans_chg;             // [R5]
    assign set_vec[`MEF_BIT_OVERRUN]   = (ovr_exp | (rx_byte_done & rx_unread))
                                         & ~rx_block;                               // [R8] [R18]
    assign set_vec[`MEF_BIT_RXREADY]   = rx_byte_done & ~rx_block;                  // [R6] [R18]
    assign set_vec[`MEF_BIT_UNDERFLOW] = und_exp & ~tx_block;                       // [R11]
    assign set_vec[`MEF_BIT_TXFREE]    = tx_slot_free & ~tx_block;                  // [R9]
    assign set_vec[`MEF_BIT_PLAIN]     = plain_chg;                                 // [R12]

    // A flag set again during its own read counts as a fresh rise, so its
    // request is not lost to the read-clear of the same cycle
    assign rise = set_vec & ~(event_flag_register & {8{~flag_rd}});   // [R1]

    // ==========================================
    // Flag register: read clears, but a set in the same cycle wins
    // Read returns the old value; a term setting now survives the clear
    always @(posedge ref_clk)
    begin
        if (!rstn)
            event_flag_register <= `MEF_RST_FLAGS;
        else if (flag_rd)
            event_flag_register <= set_vec;                        // [R2]
        else
            event_flag_register <= event_flag_register | set_vec;
    end

    // ==========================================
    // Interrupt latch: stays until flag read, mask changes ignored
    // Level request, so a host that misses an edge still sees it
    // Mask only gates new rises, never a request already raised
    always @(posedge ref_clk)
    begin
        if (!rstn)
            irq_pend <= 1'b0;
        else if (|(rise & mask))
            irq_pend <= 1'b1;                                      // [R1] [R17]
        else if (flag_rd)
            irq_pend <= 1'b0;                                      // [R2] [R21]
    end

    assign attention_request_low = ~irq_pend;                      // [R21]

    // ==========================================
    // Mask register and transmit byte writes
    // Transmit byte is write-only; a read of its address returns zero
    // Both take effect at the edge that samples the strobe
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            mask    <= `MEF_RST_MASK;
            tx_byte <= `MEF_RST_BYTE;
        end
        else
        begin
            if (reg_wr && reg_addr == `MEF_ADDR_MASK)
                mask <= reg_wdata;
            if (byte_wr)
                tx_byte <= reg_wdata;
        end
    end

    // ==========================================
    // Receive holder, updated once per completed byte
    // A new byte always overwrites; unless the receive guard holds it off,
    // the overrun flag warns the host that the previous one was lost
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            rx_hold   <= `MEF_RST_BYTE;
            rx_unread <= 1'b0;
        end
        else if (rx_byte_done)
        begin
            rx_hold   <= rx_shift_byte;                            // [R20]
            rx_unread <= 1'b1;
        end
        else if (byte_rd)
            rx_unread <= 1'b0;
    end

    // ==========================================
    // Rearm guards: after a flag read, hold off until serviced
    // Without them a host that reads the flags but not the byte
    // would see ready again for a byte it never fetched
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            rx_block <= 1'b0;
            tx_block <= 1'b0;
        end
        else
        begin
            // Only block if the pending byte is still unread
            if (byte_rd)
                rx_block <= 1'b0;
            else if (flag_rd && rx_unread)
                rx_block <= 1'b1;                                  // [R18]
            if (byte_wr)
                tx_block <= 1'b0;
            else if (flag_rd && tx_empty)
                tx_block <= 1'b1;
        end
    end

    // ==========================================
    // Transmit fill state and underflow filler
    // Empty means reset or a slot offer, and no byte has come back since
    // Filler runs from the late tick until the next byte is written
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            tx_empty      <= 1'b1;
            underflow_run <= 1'b0;
        end
        else
        begin
            if (byte_wr)
                tx_empty <= 1'b0;
            else if (tx_slot_free)
                tx_empty <= 1'b1;
            if (byte_wr)
                underflow_run <= 1'b0;
            else if (und_exp)
                underflow_run <= 1'b1;                             // [R19]
        end
    end

    // Datapath sends marks (then scrambles them) while this is high
    assign tx_send_ones = underflow_run;                           // [R19]

    // ==========================================
    // Equaliser routing: shared band means neither is used
    // Each path picks the equaliser of its own band; no state involved
    // Combinational, so routing follows the selects without delay
    assign tx_eq_high = (tx_band_select != rx_band_select) & tx_band_select;    // [R13] [R14]
    assign tx_eq_low  = (tx_band_select != rx_band_select) & ~tx_band_select;   // [R13] [R14]
    assign rx_eq_high = (tx_band_select != rx_band_select) & rx_band_select;    // [R13] [R14]
    assign rx_eq_low  = (tx_band_select != rx_band_select) & ~rx_band_select;   // [R13] [R14]

    // ==========================================
    // Read data; ringing bit lets host time rings [R16]
    // Ring bit is the registered detector level, one edge behind the pin
    // Unmapped and write-only addresses read as zero
    assign tones = `MEF_TONES_FIXED | {1'b0, ring_status, progress_tone_status,
                   carrier_status, answer_status, 2'b00, plain_ones_status};

    always @(posedge ref_clk)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `MEF_ADDR_FLAGS:  reg_rdata <= event_flag_register;
                `MEF_ADDR_MASK:   reg_rdata <= mask;
                `MEF_ADDR_TONES:  reg_rdata <= tones;
                `MEF_ADDR_RXBYTE: reg_rdata <= rx_hold;
                default:          reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

/* File: hw/mef_map.vh */
// Register map and field positions for the modem event flag block.
// Assumes a host register port with an 8-bit address and 8-bit data.
`ifndef MEF_MAP_VH
`define MEF_MAP_VH
// ==========================================
// Register addresses
`define MEF_ADDR_FLAGS     8'hEF
`define MEF_ADDR_MASK      8'hEE
`define MEF_ADDR_TONES     8'hEC
`define MEF_ADDR_RXBYTE    8'hEA
`define MEF_ADDR_TXBYTE    8'hE3
// ==========================================
// Flag bit positions
`define MEF_BIT_PARITY     7
`define MEF_BIT_RING       6
`define MEF_BIT_TONE       5
`define MEF_BIT_OVERRUN    4
`define MEF_BIT_RXREADY    3
`define MEF_BIT_UNDERFLOW  2
`define MEF_BIT_TXFREE     1
`define MEF_BIT_PLAIN      0
// ==========================================
// Reset values and timing
`define MEF_RST_FLAGS      8'h00
`define MEF_RST_MASK       8'h00
`define MEF_RST_BYTE       8'h00
`define MEF_WINDOW_BITS    4'h8
`define MEF_TONES_FIXED    8'h80
`endif

/* File: hw/mef_edge.v */
// Change detector for one status bit: pulses on either edge.
// Assumes the status input is synchronous to ref_clk.
module mef_edge
(
    input  wire ref_clk,
    input  wire rstn,
    input  wire level,
    output wire changed
);
    reg prev;   // Last sampled level

    // ==========================================
    // Sample and compare
    always @(posedge ref_clk)
    begin
        if (!rstn)
            prev <= 1'b0;
        else
            prev <= level;
    end

    assign changed = rstn & (prev ^ level);
endmodule

/* File: hw/mef_window.v */
// Eight-bit-period window timer used for receive overrun and transmit underflow.
// Assumes bit_tick pulses once per line bit period.
`include "mef_map.vh"
module mef_window
(
    input  wire ref_clk,
    input  wire rstn,
    input  wire start,
    input  wire serviced,
    input  wire bit_tick,
    output wire expired
);
    reg       armed;   // Window running
    reg [3:0] count;   // Bit periods elapsed

    // ==========================================
    // Window counter
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            armed <= 1'b0;
            count <= 4'h0;
        end
        else if (start)
        begin
            armed <= 1'b1;
            count <= 4'h0;
        end
        else if (serviced || expired)
            armed <= 1'b0;
        else if (armed && bit_tick)
            count <= count + 4'h1;
    end

    // Expiry when the eighth period ends unserviced
    assign expired = armed & ~serviced & bit_tick & (count == (`MEF_WINDOW_BITS - 4'h1));
endmodule

/* File: test/mef_top_props.sv */
// Port-level checker for the modem event flag block.
// Assumes mef_map.vh on the include path and one clock domain, ref_clk.
`include "mef_map.vh"
module mef_chk
(
    input wire       ref_clk,
    input wire       rstn,
    input wire [7:0] reg_addr,
    input wire       reg_rd,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [7:0] rx_shift_byte,
    input wire [7:0] tx_byte,
    input wire       bit_tick,
    input wire       rx_byte_done,
    input wire       tx_slot_free,
    input wire       ring_timing_node,
    input wire       progress_tone_status,
    input wire       carrier_status,
    input wire       answer_status,
    input wire       plain_ones_status,
    input wire       tx_band_select,
    input wire       rx_band_select,
    input wire       tx_send_ones,
    input wire       tx_eq_high,
    input wire       tx_eq_low,
    input wire       rx_eq_high,
    input wire       rx_eq_low,
    input wire       attention_request_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Helpers
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    wire [4:0] st = {ring_timing_node, progress_tone_status, carrier_status,
                     answer_status, plain_ones_status};
    wire       rd_fl = reg_rd && reg_addr == `MEF_ADDR_FLAGS;  // Flag read
    wire [7:0] tone_exp = {1'b1, st[4:1], 2'b00, st[0]};      // Tone word from pins
    reg  [7:0] rx_q;                                           // Newest byte
    // Mirror of the receive holder, refreshed on every completed byte
    always @(posedge ref_clk)
        if (!rstn)
            rx_q <= `MEF_RST_BYTE;
        else if (rx_byte_done)
            rx_q <= rx_shift_byte;
    // ==========================================
    // Properties
    a_eq_bypass: assert property (
        tx_band_select == rx_band_select |-> !(tx_eq_high | tx_eq_low | rx_eq_high | rx_eq_low))
        else $error("equalisers not bypassed");
    a_eq_route: assert property (
        tx_band_select != rx_band_select |-> {tx_eq_high, tx_eq_low, rx_eq_high, rx_eq_low}
        == {tx_band_select, !tx_band_select, rx_band_select, !rx_band_select})
        else $error("equaliser routing wrong");
    // Quiet read: no set term now and no status change still in flight
    a_read_clears: assert property (
        rd_fl && !(rx_byte_done | tx_slot_free | bit_tick) && $stable(st)
        && $past(st, 2) == st |=> attention_request_low)
        else $error("request low after flag read");
    a_tones_read: assert property (
        reg_rd && reg_addr == `MEF_ADDR_TONES && $stable(st)
        |=> reg_rdata == $past(tone_exp))
        else $error("tone status read wrong");
    a_rx_read: assert property (
        reg_rd && reg_addr == `MEF_ADDR_RXBYTE && !rx_byte_done |=> reg_rdata == $past(rx_q))
        else $error("receive byte read wrong");
    a_req_held: assert property (
        !attention_request_low && !rd_fl |=> !attention_request_low)
        else $error("request dropped without flag read");
    a_fill_ends: assert property (
        reg_wr && reg_addr == `MEF_ADDR_TXBYTE
        |=> tx_byte == $past(reg_wdata) && !tx_send_ones)
        else $error("write did not end filler");
    a_fill_at_tick: assert property (
        $rose(tx_send_ones) |-> $past(bit_tick) || $past(bit_tick, 2))
        else $error("filler began off a bit tick");
endmodule
bind mef_top mef_chk mef_chk_i (.*);

/* File: test/mef_host.sv */
// Host controller model on the register port of the event flag block.
// Assumes one access at a time; strobes are single-cycle pulses.
module mef_host
(
    input  wire       ref_clk,
    input  wire [7:0] reg_rdata,
    output reg  [7:0] reg_addr = 8'h00,
    output reg  [7:0] reg_wdata = 8'h00,
    output reg        reg_rd = 1'b0,
    output reg        reg_wr = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // Write: held one edge, then released with inverted leftovers
    task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
        @(negedge ref_clk);
    end
    endtask
    // Read: data is registered, taken one edge after the strobe
    task rd(input [7:0] a, output [7:0] v);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge ref_clk);
        v = reg_rdata;
    end
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for mef_top with a host model on its register port.
// Assumes mef_map.vh on the include path; bit ticks come from the bench.
`include "mef_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Stimulus state
    localparam [63:0] FLAG_TAB = 64'h8840201808060201; // Flags per event 7..0
    reg         ref_clk = 1'b0;
    reg         rstn = 1'b0;
    reg  [2:0]  stb = 3'b000;        // Byte done, slot free, bit tick
    reg  [4:0]  st = 5'h00;          // Status levels, ring first
    reg  [1:0]  band = 2'b00;        // Transmit band, receive band
    reg  [7:0]  rx_shift_byte = 8'h00;
    reg         rx_parity_bad = 1'b0;
    reg  [7:0]  d, m;
    reg  [7:0]  last_rx = `MEF_RST_BYTE;
    integer     seed = 32'hfb62;
    integer     errors = 0, n_checks = 0, cycles = 0, p, b;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata, tx_byte;
    wire        reg_rd, reg_wr, tx_send_ones, attention_request_low;
    wire        tx_eq_high, tx_eq_low, rx_eq_high, rx_eq_low;
    mef_top mef_top_i (.*, .rx_byte_done(stb[2]), .tx_slot_free(stb[1]), .bit_tick(stb[0]),
        .ring_timing_node(st[4]), .progress_tone_status(st[3]), .carrier_status(st[2]),
        .answer_status(st[1]), .plain_ones_status(st[0]),
        .tx_band_select(band[1]), .rx_band_select(band[0]));
    mef_host mef_host_i (.*);
    initial
        forever #12.5 ref_clk = ~ref_clk;
    // Hang guard, far above the expected few hundred cycles
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            report_and_stop;
        end
    end
    // ==========================================
    // Helpers
    function [7:0] exp_flags(input integer e);
        exp_flags = FLAG_TAB[8 * e +: 8];
    endfunction
    task check(input [8*10-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("Error %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // One-cycle datapath strobe with a fresh random byte
    task pulse(input [2:0] s, input par);
    begin
        @(posedge ref_clk);
        stb <= s;
        rx_parity_bad <= par;
        d = $random(seed);
        rx_shift_byte <= d;
        if (s[2])
            last_rx = d;
        @(posedge ref_clk);
        stb <= 3'b000;
    end
    endtask
    // Raise the event behind flag bit e
    task fire(input integer e);
        integer k;
    begin
        @(posedge ref_clk);
        if (e == 6 || e == 0)
            st <= st ^ (e == 6 ? 5'h10 : 5'h01);
        else if (e == 5)
            st <= st ^ (5'h08 >> ($unsigned($random(seed)) % 3));
        else
            pulse(e > 2 ? 3'b100 : 3'b010, e == 7);
        // Window cases: only the eighth tick may start the filler
        for (k = 1; k <= 8 && (e == 4 || e == 2); k = k + 1)
        begin
            pulse(3'b001, 1'b0);
            @(negedge ref_clk);
            if (e == 2)
                check("fill", tx_send_ones, k == 8);
        end
    end
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        mef_host_i.rd(`MEF_ADDR_TONES, d);
        check("tones", d, `MEF_TONES_FIXED);
        for (p = 0; p < 2; p = p + 1)
            for (b = 0; b < 8; b = b + 1)
            begin
                m = p ? $random(seed) & ~exp_flags(b) : 8'h01 << b;
                mef_host_i.wr(`MEF_ADDR_MASK, m);
                mef_host_i.rd(`MEF_ADDR_MASK, d);
                check("mask", d, m);
                fire(b);
                repeat (4) @(negedge ref_clk);
                check("request", attention_request_low, p[0]);
                mef_host_i.wr(`MEF_ADDR_MASK, 8'h00);
                check("held", attention_request_low, p[0]);
                mef_host_i.rd(`MEF_ADDR_FLAGS, d);
                check("flags", d, exp_flags(b));
                check("cleared", attention_request_low, 8'h01);
                mef_host_i.rd(`MEF_ADDR_RXBYTE, d);
                check("rx byte", d, last_rx);
                mef_host_i.wr(`MEF_ADDR_TXBYTE, d);
                mef_host_i.rd(`MEF_ADDR_FLAGS, d);
                check("again", d, 8'h00);
                check("fill end", tx_send_ones, 8'h00);
            end
        // Second byte after a flag read but before the byte is fetched
        fire(3);
        mef_host_i.rd(`MEF_ADDR_FLAGS, d);
        fire(3);
        mef_host_i.rd(`MEF_ADDR_FLAGS, d);
        check("rearm", d, 8'h00);
        mef_host_i.rd(`MEF_ADDR_RXBYTE, d);
        check("rx byte", d, last_rx);
        // Second byte over an unread one, no flag read between
        fire(3);
        fire(3);
        mef_host_i.rd(`MEF_ADDR_FLAGS, d);
        check("overrun", d, exp_flags(4));
        mef_host_i.rd(`MEF_ADDR_RXBYTE, d);
        check("rx byte", d, last_rx);
        @(posedge ref_clk);
        st <= $random(seed);
        repeat (3) @(negedge ref_clk);
        mef_host_i.rd(`MEF_ADDR_TONES, d);
        check("tones", d, {1'b1, st[4:1], 2'b00, st[0]});
        // Host times a ring: bit high while the node is, low once it drops
        @(posedge ref_clk);
        st <= 5'h10;
        repeat (3) @(negedge ref_clk);
        mef_host_i.rd(`MEF_ADDR_TONES, d);
        check("ring high", d[6], 1'b1);
        @(posedge ref_clk);
        st <= 5'h00;
        repeat (3) @(negedge ref_clk);
        mef_host_i.rd(`MEF_ADDR_TONES, d);
        check("ring low", d[6], 1'b0);
        mef_host_i.rd(8'h00, d);
        for (b = 0; b < 4; b = b + 1)
        begin
            @(posedge ref_clk);
            band <= b;
            @(negedge ref_clk);
            check("equaliser", {tx_eq_high, tx_eq_low, rx_eq_high, rx_eq_low},
                band[1] == band[0] ? 4'h0 : {band[1], !band[1], band[0], !band[0]});
        end
        report_and_stop;
    end
endmodule
